/* logic/wbuf_pkg.sv */
/*
 * package for the buffer-write command checker: cdb layout, mode codes,
 * selector codes, sense values and sizes.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package wbuf_pkg;
   localparam logic [7:0]  OPC_WRITE_BUFFER = 8'h3B;
   localparam int          CDB_BYTES        = 10;
   // cdb field positions (byte index)
   localparam int          POS_OPCODE       = 0;
   localparam int          POS_MODE         = 1;
   localparam int          POS_SELECTOR     = 2;
   localparam int          POS_OFFSET       = 3;
   localparam int          POS_COUNT        = 6;
   localparam int          MODE_W           = 4;
   // mode codes
   localparam logic [3:0]  MODE_HDR_DATA    = 4'h0;
   localparam logic [3:0]  MODE_DATA        = 4'h2;
   localparam logic [3:0]  MODE_UCODE       = 4'h4;
   localparam logic [3:0]  MODE_UCODE_SAVE  = 4'h5;
   localparam logic [3:0]  MODE_ECHO        = 4'hA;
   // buffer selectors
   localparam logic [7:0]  SEL_MAIN         = 8'h00;
   localparam logic [7:0]  SEL_MAIN_LAST    = 8'h02;
   localparam logic [7:0]  SEL_NVPARAM      = 8'h80;
   localparam logic [7:0]  SEL_RESERVED     = 8'h81;
   localparam logic [7:0]  SEL_BOOT         = 8'h82;
   // sizes
   localparam logic [23:0] HDR_BYTES        = 24'h000004;
   localparam int          SECTOR_LOG2      = 9;
   localparam logic [23:0] BUF_BYTES        = 24'h080000;
   // status and sense
   localparam logic [7:0]  STAT_GOOD        = 8'h00;
   localparam logic [7:0]  STAT_CHECK       = 8'h02;
   localparam logic [3:0]  SK_ILLEGAL_REQ   = 4'h5;
   localparam logic [7:0]  ASC_INVALID_CDB  = 8'h24;
   // payload destinations
   typedef enum logic [1:0] {
      DEST_BUFFER, DEST_CTRL_MEM, DEST_MEDIA, DEST_ECHO
   } dest_t;
endpackage : wbuf_pkg

/* logic/stream_fifo.sv */
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("stream_fifo depth must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem[rd_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : stream_fifo

/* logic/wbuf_checker.sv */
/*
 * buffer-write command checker: takes a ten-byte command block, checks
 * its fields per mode, streams the payload bytes through a fifo to the
 * chosen destination, then answers with status and sense.
 * assumes the command block arrives parallel with a one-cycle strobe,
 * payload bytes come from same-clock logic, and firmware acts on the
 * cache flush, unit attention and reset requests it is given.
 */
`timescale 1ns/10ps
// Function
// - opcode 3Bh; mode byte 1 low bits; selector, offset, count follow.
// - only modes 0000, 0010, 0100, 0101 and 1010 are supported.
// - every accepted command requests a full cache flush.
// - diagnostic buffer writes never route data to the medium.
// - header mode drops four header bytes, stores count minus four.
// - header mode: nonzero selector or offset gives illegal field.
// - header mode: count above buffer capacity gives check condition.
// - data mode accepts only selector zero.
// - data mode: offset beyond the buffer is rejected.
// - data mode: count below capacity and sector aligned.
// - microcode mode loads control memory, runs it until power cycle.
// - microcode mode accepts selectors 00h and 81h only.
// - microcode: offset zero; count matches set size; zero count no-op.
// - microcode change posts unit attention to all other initiators.
// - save mode writes reserved disk area, effective after self reset.
// - save mode accepts selectors 00h-02h, 80h, 81h; 82h only with boot flash present.
// - every field error: check condition, illegal request, invalid cdb.
// - invalid or incompatible saved code is refused, old code kept.
// - selector 00h save supports single, chunked and separate sets.
module wbuf_checker #(
   parameter int          FIFO_DEPTH = 8,
   parameter logic [23:0] BUF_SIZE   = wbuf_pkg::BUF_BYTES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // command block
   input  wire logic [79:0] cdb,
   input  wire logic        cdb_valid,
   input  wire logic [2:0]  initiator_id,
   // expected data set size for microcode loads
   input  wire logic [23:0] set_size,
   input  wire logic        boot_flash_present,
   // firmware verdict on saved code
   input  wire logic        code_check_done,
   input  wire logic        code_compatible,
   // payload in
   input  wire logic [7:0]  pay_data,
   input  wire logic        pay_valid,
   output logic             pay_ready,
   // payload out
   output logic [7:0]       out_data,
   output logic             out_valid,
   output logic [1:0]       out_dest,
   input  wire logic        out_ready,
   // completion
   output logic             done,
   output logic [7:0]       status,
   output logic [3:0]       sense_key,
   output logic [7:0]       sense_asc,
   // side effects
   output logic             cache_flush,
   output logic             ucode_run,
   output logic             ua_post,
   output logic [2:0]       ua_skip_id,
   output logic             save_commit,
   output logic             self_reset_req,
   output logic             code_rejected,
   output logic             busy
);
   initial begin
      if (BUF_SIZE <= wbuf_pkg::HDR_BYTES) begin
         $error("wbuf_checker buffer size too small");
      end
   end

   typedef enum logic [2:0] {
      ST_IDLE, ST_SKIP, ST_MOVE, ST_DRAIN, ST_VERIFY, ST_DONE
   } state_t;

   state_t      state_q;
   logic [3:0]  mode_q;
   logic [7:0]  sel_q;
   logic [23:0] cnt_q;
   logic [2:0]  skip_q;
   logic [1:0]  dest_q;
   logic [2:0]  ini_q;

   // field views
   logic [7:0]  f_opc;
   logic [3:0]  f_mode;
   logic [7:0]  f_sel;
   logic [23:0] f_off;
   logic [23:0] f_cnt;
   logic        bad;
   logic        sel_ok;

   always_comb begin
      f_opc  = cdb[79-8*wbuf_pkg::POS_OPCODE -: 8];
      f_mode = cdb[79-8*wbuf_pkg::POS_MODE-4 -: wbuf_pkg::MODE_W];
      f_sel  = cdb[79-8*wbuf_pkg::POS_SELECTOR -: 8];
      f_off  = cdb[79-8*wbuf_pkg::POS_OFFSET -: 24];
      f_cnt  = cdb[79-8*wbuf_pkg::POS_COUNT -: 24];
      bad    = 1'b0;
      sel_ok = 1'b0;
      case (f_mode)
         wbuf_pkg::MODE_HDR_DATA: begin
            bad = (f_sel != 8'h00) || (f_off != 24'h000000)
               || (f_cnt > BUF_SIZE)
               || (f_cnt != 24'h000000 && f_cnt < wbuf_pkg::HDR_BYTES);
         end
         wbuf_pkg::MODE_DATA: begin
            bad = (f_sel != 8'h00) || (f_off >= BUF_SIZE)
               || (f_cnt >= BUF_SIZE)
               || (f_cnt[wbuf_pkg::SECTOR_LOG2-1:0] != '0)
               || (f_off + f_cnt > BUF_SIZE);
         end
         wbuf_pkg::MODE_UCODE: begin
            sel_ok = (f_sel == wbuf_pkg::SEL_MAIN)
               || (f_sel == wbuf_pkg::SEL_RESERVED);
            // zero offset, exact size or zero
            bad = !sel_ok || (f_off != 24'h000000)
               || (f_cnt != 24'h000000 && f_cnt != set_size);
         end
         wbuf_pkg::MODE_UCODE_SAVE: begin
            // 00h to 02h cover all main code variants
            sel_ok = (f_sel <= wbuf_pkg::SEL_MAIN_LAST)
               || (f_sel == wbuf_pkg::SEL_NVPARAM)
               || (f_sel == wbuf_pkg::SEL_RESERVED)
               || (f_sel == wbuf_pkg::SEL_BOOT && boot_flash_present);
            bad = !sel_ok || (f_off != 24'h000000);
         end
         wbuf_pkg::MODE_ECHO: begin
            bad = (f_cnt > BUF_SIZE);
         end
         default: begin
            bad = 1'b1;
         end
      endcase
   end

   logic [7:0] q_data;
   logic       q_valid;
   logic       q_ready;
   logic       take;
   logic       q_push;

   // intake only while moving or skipping header; fifo full stalls it
   assign take   = pay_valid && pay_ready;
   assign q_push = take && (state_q == ST_MOVE);

   stream_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rstn      (rstn),
      .in_data   (pay_data),
      .in_valid  (pay_valid && state_q == ST_MOVE),
      .in_ready  (q_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (!out_valid || out_ready)
   );

   always_comb begin
      case (state_q)
         ST_SKIP: pay_ready = 1'b1;
         ST_MOVE: pay_ready = q_ready;
         default: pay_ready = 1'b0;
      endcase
   end

   // main sequence
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         mode_q  <= 4'h0;
         sel_q   <= 8'h00;
         cnt_q   <= 24'h000000;
         skip_q  <= 3'h0;
         dest_q  <= 2'h0;
         ini_q   <= 3'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cdb_valid && f_opc == wbuf_pkg::OPC_WRITE_BUFFER) begin
                  mode_q <= f_mode;
                  sel_q  <= f_sel;
                  ini_q  <= initiator_id;
                  if (bad || f_cnt == 24'h000000) begin
                     cnt_q   <= 24'h000000;
                     state_q <= ST_DONE;
                  end else if (f_mode == wbuf_pkg::MODE_HDR_DATA) begin
                     // skip header, store count minus four
                     cnt_q   <= f_cnt - wbuf_pkg::HDR_BYTES;
                     skip_q  <= 3'(wbuf_pkg::HDR_BYTES);
                     state_q <= ST_SKIP;
                  end else begin
                     cnt_q   <= f_cnt;
                     state_q <= ST_MOVE;
                  end
                  case (f_mode)
                     wbuf_pkg::MODE_UCODE:
                        dest_q <= 2'(wbuf_pkg::DEST_CTRL_MEM);
                     wbuf_pkg::MODE_UCODE_SAVE:
                        dest_q <= 2'(wbuf_pkg::DEST_MEDIA);
                     wbuf_pkg::MODE_ECHO:
                        dest_q <= 2'(wbuf_pkg::DEST_ECHO);
                     default:
                        dest_q <= 2'(wbuf_pkg::DEST_BUFFER);
                  endcase
               end
            end
            ST_SKIP: begin
               if (take) begin
                  skip_q <= skip_q - 3'h1;
                  if (skip_q == 3'h1) begin
                     state_q <= (cnt_q == 24'h000000) ? ST_DRAIN : ST_MOVE;
                  end
               end
            end
            ST_MOVE: begin
               if (q_push) begin
                  cnt_q <= cnt_q - 24'h000001;
                  if (cnt_q == 24'h000001) begin
                     state_q <= ST_DRAIN;
                  end
               end
            end
            ST_DRAIN: begin
               if (!q_valid && (!out_valid || out_ready)) begin
                  state_q <= (mode_q == wbuf_pkg::MODE_UCODE_SAVE)
                     ? ST_VERIFY : ST_DONE;
               end
            end
            ST_VERIFY: begin
               if (code_check_done) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // output stage
   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_valid <= 1'b0;
         out_data  <= 8'h00;
      end else if (!out_valid || out_ready) begin
         out_valid <= q_valid;
         out_data  <= q_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_dest <= 2'h0;
         busy     <= 1'b0;
      end else begin
         out_dest <= dest_q;
         busy     <= (state_q != ST_IDLE);
      end
   end

   logic ok_end;
   logic load_end;
   logic done_bad;
   logic moved_q;

   assign ok_end   = (state_q == ST_DONE) && !done_bad;
   assign load_end = ok_end && cnt_q == 24'h000000 && moved_q;

   // bad field flag held per command
   always_ff @(posedge clk) begin
      if (!rstn) begin
         done_bad <= 1'b0;
         moved_q  <= 1'b0;
      end else if (state_q == ST_IDLE && cdb_valid
                   && f_opc == wbuf_pkg::OPC_WRITE_BUFFER) begin
         done_bad <= bad;
         moved_q  <= !bad && f_cnt != 24'h000000;
      end else if (state_q == ST_VERIFY && code_check_done
                   && !code_compatible) begin
         moved_q <= 1'b0;
      end
   end

   // completion and side effects; done and flags are one-cycle pulses, ua_skip_id holds the issuer; status and sense hold until the next completion
   always_ff @(posedge clk) begin
      if (!rstn) begin
         done           <= 1'b0;
         status         <= wbuf_pkg::STAT_GOOD;
         sense_key      <= 4'h0;
         sense_asc      <= 8'h00;
         cache_flush    <= 1'b0;
         ucode_run      <= 1'b0;
         ua_post        <= 1'b0;
         ua_skip_id     <= 3'h0;
         save_commit    <= 1'b0;
         self_reset_req <= 1'b0;
         code_rejected  <= 1'b0;
      end else begin
         done          <= (state_q == ST_DONE);
         cache_flush   <= ok_end;
         ucode_run     <= load_end && mode_q == wbuf_pkg::MODE_UCODE;
         ua_post       <= load_end && mode_q == wbuf_pkg::MODE_UCODE;
         ua_skip_id    <= ini_q;
         save_commit   <= load_end && mode_q == wbuf_pkg::MODE_UCODE_SAVE;
         self_reset_req <= load_end
            && mode_q == wbuf_pkg::MODE_UCODE_SAVE;
         code_rejected <= (state_q == ST_VERIFY) && code_check_done
            && !code_compatible;
         if (state_q == ST_DONE) begin
            // check condition, illegal request, invalid cdb
            status    <= done_bad ? wbuf_pkg::STAT_CHECK
                                  : wbuf_pkg::STAT_GOOD;
            sense_key <= done_bad ? wbuf_pkg::SK_ILLEGAL_REQ : 4'h0;
            sense_asc <= done_bad ? wbuf_pkg::ASC_INVALID_CDB : 8'h00;
         end
      end
   end
endmodule : wbuf_checker

/* test/wbuf_checker_asserts.sv */
/*
 * concurrent checks for wbuf_checker, bound to its top-level ports.
 * assumes one clock and the synchronous active-low reset of the block.
 */
`timescale 1ns/10ps
module wbuf_checker_sva #(
   parameter int          FIFO_DEPTH = 8,
   parameter logic [23:0] BUF_SIZE   = wbuf_pkg::BUF_BYTES
) (
   // clock, reset and command
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [79:0] cdb,
   input  wire logic        cdb_valid,
   input  wire logic [2:0]  initiator_id,
   // payload
   input  wire logic        out_valid,
   input  wire logic [1:0]  out_dest,
   // completion and side effects
   input  wire logic        done,
   input  wire logic [7:0]  status,
   input  wire logic [3:0]  sense_key,
   input  wire logic [7:0]  sense_asc,
   input  wire logic        cache_flush,
   input  wire logic        ua_post,
   input  wire logic [2:0]  ua_skip_id,
   input  wire logic        self_reset_req,
   input  wire logic        busy
);
   logic        take;
   logic [3:0]  md;
   logic [7:0]  sel;
   logic [23:0] cnt;
   logic [3:0]  mode_q;
   logic [2:0]  id_q;

   assign md   = cdb[67:64];
   assign sel  = cdb[63:56];
   assign cnt  = cdb[31:8];
   assign take = cdb_valid && !busy
                 && cdb[79:72] == wbuf_pkg::OPC_WRITE_BUFFER;

   // mode and issuer of the command in flight
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_q <= 4'h0;
         id_q   <= 3'h0;
      end else if (take) begin
         mode_q <= md;
         id_q   <= initiator_id;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence reject_s;
      !out_valid ##1 (done && status == wbuf_pkg::STAT_CHECK);
   endsequence

   bad_mode_a: assert property (
      take && !(md inside {4'h0, 4'h2, 4'h4, 4'h5, 4'hA}) |=> reject_s)
      else $error("unsupported mode not rejected");
   hdr_field_a: assert property (
      take && md == 4'h0 && (sel != 8'h00 || cdb[55:32] != 24'h0)
      |=> reject_s) else $error("header mode field not rejected");
   hdr_size_a: assert property (
      take && md == 4'h0 && cnt > BUF_SIZE |=> reject_s)
      else $error("header mode oversize not rejected");
   data_field_a: assert property (
      take && md == 4'h2 && (sel != 8'h00 || cnt[8:0] != 9'h0)
      |=> reject_s) else $error("data mode field not rejected");
   ucode_sel_a: assert property (
      take && md == 4'h4 && !(sel inside {8'h00, 8'h81}) |=> reject_s)
      else $error("microcode selector not rejected");
   save_sel_a: assert property (
      take && md == 4'h5 && !(sel inside {[8'h00:8'h02], [8'h80:8'h82]})
      |=> reject_s) else $error("save selector not rejected");
   sense_code_a: assert property (
      done && status == wbuf_pkg::STAT_CHECK |-> sense_key == 4'h5
      && sense_asc == 8'h24) else $error("wrong sense on check");
   flush_good_a: assert property (
      cache_flush == (done && status == wbuf_pkg::STAT_GOOD))
      else $error("cache flush not tied to good completion");
   media_save_a: assert property (
      out_valid && out_dest == 2'h2 |-> mode_q == 4'h5)
      else $error("media written outside save mode");
   ucode_dest_a: assert property (
      out_valid && mode_q == 4'h4 |-> out_dest == 2'h1)
      else $error("microcode not sent to control memory");
   ua_skip_a: assert property (
      ua_post |-> ua_skip_id == id_q)
      else $error("unit attention skips wrong initiator");
   self_reset_a: assert property (
      self_reset_req |-> mode_q == 4'h5 && $past(busy))
      else $error("self reset outside save mode");
endmodule : wbuf_checker_sva

bind wbuf_checker wbuf_checker_sva #(
   .FIFO_DEPTH (FIFO_DEPTH),
   .BUF_SIZE   (BUF_SIZE)
) sva_u (.clk, .rstn, .cdb, .cdb_valid, .initiator_id, .out_valid,
   .out_dest, .done, .status, .sense_key, .sense_asc, .cache_flush,
   .ua_post, .ua_skip_id, .self_reset_req, .busy);

/* test/init_src.sv */
/*
 * initiator payload source: sends len bytes 00,01,.. on valid/ready.
 * assumes go is a one-cycle pulse given with the command block.
 */
`timescale 1ns/10ps
module init_src (
   // clock and control
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        go,
   input  wire logic [23:0] len,
   input  wire logic        slow,
   // payload
   output logic [7:0]       pay_data,
   output logic             pay_valid,
   input  wire logic        pay_ready
);
   logic [23:0] rem_q  = 24'h0;
   logic [23:0] idx_q  = 24'h0;
   logic [7:0]  last_q = 8'h00;
   logic        gap_q  = 1'b0;

   always @(posedge clk) begin
      if (!rstn) begin
         rem_q <= 24'h0;
         gap_q <= 1'b0;
      end else if (go) begin
         rem_q <= len;
         idx_q <= 24'h0;
         gap_q <= 1'b0;
      end else if (pay_valid && pay_ready) begin
         rem_q  <= rem_q - 24'h1;
         idx_q  <= idx_q + 24'h1;
         last_q <= idx_q[7:0];
         gap_q  <= slow;
      end else begin
         gap_q  <= 1'b0;
      end
   end

   // idle line shows the inverse so a stale byte never looks valid
   assign pay_valid = rem_q != 24'h0 && !gap_q;
   assign pay_data  = pay_valid ? idx_q[7:0] : ~last_q;
endmodule : init_src

/* test/wbuf_checker_tb.sv */
/*
 * self-checking bench for wbuf_checker with an initiator model.
 * assumes the package, fifo and design are compiled first.
 */
`timescale 1ns/10ps
module wbuf_checker_tb;
   logic        clk = 0, rstn = 0, cdb_valid = 0, go = 0, slow = 0;
   logic        bfp = 0, chk_done = 0, compat = 1, out_ready = 1;
   logic [79:0] cdb = 80'h0;
   logic [23:0] set_size = 24'h000010, len = 24'h0;
   logic [23:0] n_out = 24'h0, skip = 24'h0;
   logic [2:0]  initiator_id = 3'h5, ua_skip_id;
   logic [7:0]  pay_data, out_data, status, sense_asc;
   logic        pay_valid, pay_ready, out_valid, done, busy;
   logic [1:0]  out_dest, exp_dest = 2'h0;
   logic [3:0]  sense_key;
   logic [5:0]  fx, seen = 6'h00;
   int          mismatches = 0, checks = 0;
   logic [59:0] bad [12] = '{60'h0_01_000000_000008,
      60'h0_00_000004_000008, 60'h0_00_000000_080005,
      60'h2_01_000000_000200, 60'h2_00_0FFFFF_000200,
      60'h2_00_000000_000201, 60'h2_00_000000_080000,
      60'h4_01_000000_000010, 60'h5_03_000000_000010,
      60'h1_00_000000_000008, 60'hF_00_000000_000008,
      60'h5_82_000000_000080};

   wbuf_checker #(.FIFO_DEPTH(8)) dut_u (.clk(clk), .rstn(rstn),
      .cdb(cdb), .cdb_valid(cdb_valid), .initiator_id(initiator_id),
      .set_size(set_size), .boot_flash_present(bfp),
      .code_check_done(chk_done), .code_compatible(compat),
      .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
      .out_data(out_data), .out_valid(out_valid), .out_dest(out_dest),
      .out_ready(out_ready), .done(done), .status(status),
      .sense_key(sense_key), .sense_asc(sense_asc),
      .cache_flush(fx[5]), .ucode_run(fx[4]), .ua_post(fx[3]),
      .ua_skip_id(ua_skip_id), .save_commit(fx[2]),
      .self_reset_req(fx[1]), .code_rejected(fx[0]), .busy(busy));

   init_src src_u (.clk(clk), .rstn(rstn), .go(go), .len(len),
      .slow(slow), .pay_data(pay_data), .pay_valid(pay_valid),
      .pay_ready(pay_ready));

   always #20 clk = ~clk;

   task chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // counters restart with each command, so only this process writes them
   always @(posedge clk) begin
      seen <= go ? 6'h00 : (seen | fx);
      if (go) begin
         n_out <= 24'h0;
      end else if (out_valid && out_ready) begin
         chk({16'h0, out_data}, {16'h0, 8'(n_out + skip)});
         chk({22'h0, out_dest}, {22'h0, exp_dest});
         n_out <= n_out + 24'h1;
      end
   end

   task run(input logic [3:0] md, input logic [7:0] sel,
            input logic [23:0] off, input logic [23:0] cnt,
            input logic [7:0] st, input logic [5:0] ex);
      @(negedge clk);
      cdb       = {8'h3B, 4'h0, md, sel, off, cnt, 8'h00};
      cdb_valid = 1'b1;
      go        = 1'b1;
      len       = (st == wbuf_pkg::STAT_GOOD) ? cnt : 24'h0;
      @(negedge clk);
      cdb_valid = 1'b0;
      go        = 1'b0;
      for (int i = 0; i < 4000 && done !== 1'b1; i++) @(negedge clk);
      chk({23'h0, done}, 24'h1);
      chk({16'h0, status}, {16'h0, st});
      if (st == wbuf_pkg::STAT_CHECK)
         chk({12'h0, sense_key, sense_asc}, 24'h000524);
      @(negedge clk);
      chk(n_out, (st == wbuf_pkg::STAT_GOOD) ? cnt - skip : 24'h0);
      chk({18'h0, seen}, {18'h0, ex});
   endtask : run

   task t_data;
      out_ready = 1'b0;
      fork
         begin
            repeat (40) @(negedge clk);
            // buffer full while the sink stalls
            chk({23'h0, pay_ready}, 24'h0);
            chk(n_out, 24'h0);
            out_ready = 1'b1;
         end
      join_none
      run(4'h2, 8'h00, 24'h0, 24'h000200, 8'h00, 6'h20);
      $display("test data done");
   endtask : t_data

   task t_bad;
      for (int i = 0; i < 12; i++)
         run(bad[i][59:56], bad[i][55:48], bad[i][47:24], bad[i][23:0],
             8'h02, 6'h00);
      $display("test field errors done");
   endtask : t_bad

   task t_hdr;
      skip = 24'h4;
      run(4'h0, 8'h00, 24'h0, 24'h000008, 8'h00, 6'h20);
      skip = 24'h0;
      $display("test header done");
   endtask : t_hdr

   task t_ucode;
      exp_dest     = 2'h1;
      initiator_id = 3'h3;
      run(4'h4, 8'h00, 24'h0, set_size, 8'h00, 6'h38);
      chk({21'h0, ua_skip_id}, 24'h3);
      initiator_id = 3'h5;
      run(4'h4, 8'h81, 24'h0, 24'h0, 8'h00, 6'h20);
      $display("test microcode done");
   endtask : t_ucode

   task t_save;
      exp_dest = 2'h2;
      slow     = 1'b1;
      chk_done = 1'b1;
      run(4'h5, 8'h80, 24'h0, 24'h000080, 8'h00, 6'h26);
      bfp      = 1'b1;
      run(4'h5, 8'h82, 24'h0, 24'h000080, 8'h00, 6'h26);
      compat   = 1'b0;
      run(4'h5, 8'h00, 24'h0, 24'h000080, 8'h00, 6'h21);
      compat   = 1'b1;
      bfp      = 1'b0;
      slow     = 1'b0;
      chk_done = 1'b0;
      $display("test save done");
   endtask : t_save

   task t_echo;
      exp_dest = 2'h3;
      run(4'hA, 8'h00, 24'h0, 24'h000010, 8'h00, 6'h20);
      $display("test echo done");
   endtask : t_echo

   task finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      t_data;
      t_bad;
      t_hdr;
      t_ucode;
      t_save;
      t_echo;
      finish_test;
   end

   // tests need about 1500 cycles
   initial begin
      repeat (20000) @(negedge clk);
      mismatches++;
      finish_test;
   end
endmodule : wbuf_checker_tb
